/* inc/t16_cfg.svh */
`ifndef T16_CFG_SVH
`define T16_CFG_SVH

// Byte addresses of the timer registers on the 8-bit access port
`define T16_A_CNT_L   4'h0
`define T16_A_CNT_H   4'h1
`define T16_A_CAP_L   4'h2
`define T16_A_CAP_H   4'h3
`define T16_A_CMPA_L  4'h4
`define T16_A_CMPA_H  4'h5
`define T16_A_CMPB_L  4'h6
`define T16_A_CMPB_H  4'h7
`define T16_A_CMPC_L  4'h8
`define T16_A_CMPC_H  4'h9
`define T16_A_CTRL_A  4'hA
`define T16_A_CTRL_B  4'hB
`define T16_A_CTRL_C  4'hC
`define T16_A_FLAG    4'hD
`define T16_A_MASK    4'hE

// Control fields
`define T16_CA_WGM_LO   1:0
`define T16_CB_CS       2:0
`define T16_CB_WGM_HI   4:3
`define T16_CB_EDGE     6
`define T16_CB_FILT     7
`define T16_CC_SRC_CMP  0

// Clock select codes
`define T16_CS_STOP     3'h0
`define T16_CS_SYS      3'h1
`define T16_CS_P8       3'h2
`define T16_CS_P64      3'h3
`define T16_CS_P256     3'h4
`define T16_CS_P1024    3'h5
`define T16_CS_EXT_FALL 3'h6
`define T16_CS_EXT_RISE 3'h7

// Flag and mask bit positions
`define T16_F_OVF  0
`define T16_F_CMPA 1
`define T16_F_CMPB 2
`define T16_F_CMPC 3
`define T16_F_CAP  5
`define T16_F_USED 8'h2F

// Waveform modes
`define T16_M_NORMAL   4'h0
`define T16_M_PC8      4'h1
`define T16_M_PC9      4'h2
`define T16_M_PC10     4'h3
`define T16_M_CTC_A    4'h4
`define T16_M_FP8      4'h5
`define T16_M_FP9      4'h6
`define T16_M_FP10     4'h7
`define T16_M_CTC_CAP  4'hC
`define T16_M_FP_CAP   4'hE
`define T16_M_FP_A     4'hF

// Count limits
`define T16_BOTTOM  16'h0000
`define T16_MAX     16'hFFFF
`define T16_TOP8    16'h00FF
`define T16_TOP9    16'h01FF
`define T16_TOP10   16'h03FF
`define T16_ONE     16'h0001

// Noise filter length in samples
`define T16_FILT_LEN 4

`endif

/* inc/t16_pkg.sv */
package t16_pkg;
    typedef logic [7:0]  t16_byte_t;
    typedef logic [15:0] t16_word_t;
    typedef logic [3:0]  t16_addr_t;
    typedef logic [3:0]  t16_mode_t;
    typedef logic [2:0]  t16_chan_t;
    typedef logic [3:0]  t16_presc_t;
endpackage

/* logic/t16_filter.sv */
`timescale 1ns/100ps
`include "t16_cfg.svh"
module t16_filter (
    input  wire logic i_clock,
    input  wire logic i_rst_b,
    input  wire logic i_enable,
    input  wire logic i_sample,
    output logic      o_level
);
    import t16_pkg::*;

    logic [`T16_FILT_LEN-1:0] hist_q;

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            hist_q <= '0;
        end else begin
            hist_q <= {hist_q[`T16_FILT_LEN-2:0], i_sample};
        end
    end

    // When enabled, level moves only after a full run of equal samples, so spikes are dropped; when disabled it follows the sample
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_level <= 1'b0;
        end else if (!i_enable) begin
            o_level <= i_sample;
        end else if (&hist_q) begin
            o_level <= 1'b1;
        end else if (~|hist_q) begin
            o_level <= 1'b0;
        end
    end
endmodule

/* logic/t16_core.sv */
`timescale 1ns/100ps
`include "t16_cfg.svh"
module t16_core (
    input  wire logic        i_clock,
    input  wire logic        i_rst_b,
    input  wire logic        i_power_gate,
    input  t16_pkg::t16_addr_t i_bus_addr,
    input  wire logic        i_bus_wr,
    input  wire logic        i_bus_rd,
    input  t16_pkg::t16_byte_t i_bus_wdata,
    input  t16_pkg::t16_presc_t i_presc_tick,
    input  wire logic        i_external_tick_pin,
    input  wire logic        i_snapshot_trigger_pin,
    input  wire logic        i_cmp_event,
    input  wire logic [5:0]  i_irq_ack,
    output t16_pkg::t16_byte_t o_bus_rdata,
    output t16_pkg::t16_chan_t o_match_wave_pins,
    output logic [5:0]       o_irq
);
    import t16_pkg::*;

    t16_word_t count_value_reg_q;
    t16_word_t snapshot_value_reg_q;
    t16_word_t match_buf_q [3];
    t16_word_t match_value_regs_q [3];
    t16_byte_t temp_q;
    t16_byte_t ctrl_a_q, ctrl_b_q, ctrl_c_q;
    t16_byte_t timer_flag_reg_q;
    t16_byte_t timer_irq_enable_reg_q;
    logic [2:0] ext_sync_q, trg_sync_q, cmpev_sync_q;
    logic       cap_lvl, cap_lvl_q;
    t16_mode_t  mode;
    t16_word_t  top;
    logic       timer_tick, at_top, cap_evt, cnt_wr;
    t16_chan_t  match;
    t16_byte_t  flag_set, flag_clr;

    function automatic t16_word_t top_of(t16_mode_t m, t16_word_t a, t16_word_t c);
        case (m)
            `T16_M_PC8, `T16_M_FP8:      top_of = `T16_TOP8;
            `T16_M_PC9, `T16_M_FP9:      top_of = `T16_TOP9;
            `T16_M_PC10, `T16_M_FP10:    top_of = `T16_TOP10;
            `T16_M_CTC_A, `T16_M_FP_A:   top_of = a;
            `T16_M_CTC_CAP, `T16_M_FP_CAP: top_of = c;
            default:                     top_of = `T16_MAX;
        endcase
    endfunction

    function automatic logic is_pwm(t16_mode_t m);
        case (m)
            `T16_M_PC8, `T16_M_PC9, `T16_M_PC10, `T16_M_FP8, `T16_M_FP9,
            `T16_M_FP10, `T16_M_FP_CAP, `T16_M_FP_A: is_pwm = 1'b1;
            default:                                 is_pwm = 1'b0;
        endcase
    endfunction

    function automatic logic wr_at(t16_addr_t a);
        wr_at = i_bus_wr && (i_bus_addr == a);
    endfunction

    assign mode   = {ctrl_b_q[`T16_CB_WGM_HI], ctrl_a_q[`T16_CA_WGM_LO]};
    assign top    = top_of(mode, match_value_regs_q[0], snapshot_value_reg_q);
    assign at_top = (count_value_reg_q == top);
    // Spelled out: a continuous assign only wakes on its arguments, not on bus pins read inside
    assign cnt_wr = i_bus_wr && (i_bus_addr == `T16_A_CNT_L);

    // Pins cross into this clock through two flops before any use
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            ext_sync_q   <= '0;
            trg_sync_q   <= '0;
            cmpev_sync_q <= '0;
        end else begin
            ext_sync_q   <= {ext_sync_q[1:0], i_external_tick_pin};
            trg_sync_q   <= {trg_sync_q[1:0], i_snapshot_trigger_pin};
            cmpev_sync_q <= {cmpev_sync_q[1:0], i_cmp_event};
        end
    end

    always_comb begin
        case (ctrl_b_q[`T16_CB_CS])
            `T16_CS_SYS:      timer_tick = 1'b1;
            `T16_CS_P8:       timer_tick = i_presc_tick[0];
            `T16_CS_P64:      timer_tick = i_presc_tick[1];
            `T16_CS_P256:     timer_tick = i_presc_tick[2];
            `T16_CS_P1024:    timer_tick = i_presc_tick[3];
            `T16_CS_EXT_FALL: timer_tick = ext_sync_q[2] && !ext_sync_q[1];
            `T16_CS_EXT_RISE: timer_tick = !ext_sync_q[2] && ext_sync_q[1];
            default:          timer_tick = 1'b0;
        endcase
        if (i_power_gate) begin
            timer_tick = 1'b0;
        end
    end

    // Counter: a processor write overrides wrap and count
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            count_value_reg_q <= `T16_BOTTOM;
        end else if (cnt_wr) begin
            count_value_reg_q <= {temp_q, i_bus_wdata};
        end else if (timer_tick) begin
            count_value_reg_q <= at_top ? `T16_BOTTOM : count_value_reg_q + `T16_ONE;
        end
    end

    // Compare buffers reload at top in PWM modes so the period changes cleanly
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            for (int i = 0; i < 3; i++) begin
                match_buf_q[i]        <= `T16_BOTTOM;
                match_value_regs_q[i] <= `T16_BOTTOM;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wr_at(t16_addr_t'(`T16_A_CMPA_L + 2 * i))) begin
                    match_buf_q[i] <= {temp_q, i_bus_wdata};
                end
                if (!is_pwm(mode) || (timer_tick && at_top)) begin
                    match_value_regs_q[i] <= match_buf_q[i];
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            match[i] = timer_tick && (count_value_reg_q == match_value_regs_q[i]);
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_match_wave_pins <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (is_pwm(mode)) begin
                    o_match_wave_pins[i] <= (i == 0 && mode == `T16_M_FP_A) ? 1'b0
                        : (count_value_reg_q < match_value_regs_q[i]);
                end else if (match[i]) begin
                    o_match_wave_pins[i] <= !o_match_wave_pins[i];
                end
            end
        end
    end

    t16_filter u_filter (
        .i_clock  (i_clock),
        .i_rst_b  (i_rst_b),
        .i_enable (ctrl_b_q[`T16_CB_FILT]),
        .i_sample (ctrl_c_q[`T16_CC_SRC_CMP] ? cmpev_sync_q[2] : trg_sync_q[2]),
        .o_level  (cap_lvl)
    );

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            cap_lvl_q <= 1'b0;
        end else begin
            cap_lvl_q <= cap_lvl;
        end
    end

    // Capture is off while the snapshot register sets the ceiling
    assign cap_evt = (cap_lvl != cap_lvl_q) && (cap_lvl == ctrl_b_q[`T16_CB_EDGE])
                     && !i_power_gate && (mode != `T16_M_CTC_CAP) && (mode != `T16_M_FP_CAP);

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            snapshot_value_reg_q <= `T16_BOTTOM;
        end else if (cap_evt) begin
            snapshot_value_reg_q <= count_value_reg_q;
        end else if (wr_at(`T16_A_CAP_L)) begin
            snapshot_value_reg_q <= {temp_q, i_bus_wdata};
        end
    end

    // Shared high byte: loaded by any high write or by a counter/snapshot low read
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            temp_q <= '0;
        end else if (i_bus_wr && i_bus_addr[0] && i_bus_addr < `T16_A_CTRL_A) begin
            temp_q <= i_bus_wdata;
        end else if (i_bus_rd && i_bus_addr == `T16_A_CNT_L) begin
            temp_q <= count_value_reg_q[15:8];
        end else if (i_bus_rd && i_bus_addr == `T16_A_CAP_L) begin
            temp_q <= snapshot_value_reg_q[15:8];
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            ctrl_a_q               <= '0;
            ctrl_b_q               <= '0;
            ctrl_c_q               <= '0;
            timer_irq_enable_reg_q <= '0;
        end else begin
            if (wr_at(`T16_A_CTRL_A)) ctrl_a_q <= i_bus_wdata;
            if (wr_at(`T16_A_CTRL_B)) ctrl_b_q <= i_bus_wdata;
            if (wr_at(`T16_A_CTRL_C)) ctrl_c_q <= i_bus_wdata;
            if (wr_at(`T16_A_MASK)) timer_irq_enable_reg_q <= i_bus_wdata & `T16_F_USED;
        end
    end

    always_comb begin
        flag_set = '0;
        flag_set[`T16_F_OVF]  = timer_tick && at_top && !cnt_wr;
        flag_set[`T16_F_CMPA] = match[0];
        flag_set[`T16_F_CMPB] = match[1];
        flag_set[`T16_F_CMPC] = match[2];
        flag_set[`T16_F_CAP]  = cap_evt;
        flag_clr = {2'b00, i_irq_ack} | (wr_at(`T16_A_FLAG) ? i_bus_wdata : '0);
    end

    // A set in the same cycle as a clear wins, so no event is lost
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            timer_flag_reg_q <= '0;
            o_irq            <= '0;
        end else begin
            timer_flag_reg_q <= ((timer_flag_reg_q & ~flag_clr) | flag_set) & `T16_F_USED;
            o_irq <= timer_flag_reg_q[5:0] & timer_irq_enable_reg_q[5:0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_bus_rdata <= '0;
        end else if (i_bus_rd) begin
            case (i_bus_addr)
                `T16_A_CNT_L:  o_bus_rdata <= count_value_reg_q[7:0];
                `T16_A_CAP_L:  o_bus_rdata <= snapshot_value_reg_q[7:0];
                `T16_A_CNT_H, `T16_A_CAP_H: o_bus_rdata <= temp_q;
                `T16_A_CMPA_L: o_bus_rdata <= match_buf_q[0][7:0];
                `T16_A_CMPA_H: o_bus_rdata <= match_buf_q[0][15:8];
                `T16_A_CMPB_L: o_bus_rdata <= match_buf_q[1][7:0];
                `T16_A_CMPB_H: o_bus_rdata <= match_buf_q[1][15:8];
                `T16_A_CMPC_L: o_bus_rdata <= match_buf_q[2][7:0];
                `T16_A_CMPC_H: o_bus_rdata <= match_buf_q[2][15:8];
                `T16_A_CTRL_A: o_bus_rdata <= ctrl_a_q;
                `T16_A_CTRL_B: o_bus_rdata <= ctrl_b_q;
                `T16_A_CTRL_C: o_bus_rdata <= ctrl_c_q;
                `T16_A_FLAG:   o_bus_rdata <= timer_flag_reg_q;
                `T16_A_MASK:   o_bus_rdata <= timer_irq_enable_reg_q;
                default:       o_bus_rdata <= '0;
            endcase
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    a_cnt_write_prio: assert property (cnt_wr |=>
        count_value_reg_q == {$past(temp_q), $past(i_bus_wdata)})
        else $error("counter write lost");
    a_temp_latch_rd: assert property (i_bus_rd && i_bus_addr == `T16_A_CNT_L && !i_bus_wr
        |=> temp_q == $past(count_value_reg_q[15:8]))
        else $error("temp not latched on low read");
    a_cmp_read_direct: assert property (i_bus_rd && i_bus_addr == `T16_A_CMPB_H && !i_bus_wr
        |=> o_bus_rdata == $past(match_buf_q[1][15:8]) && $stable(temp_q))
        else $error("compare high read wrong");
    a_match_flag_set: assert property (match[1] |=> timer_flag_reg_q[`T16_F_CMPB])
        else $error("match flag not set");
    a_stop_idle: assert property (ctrl_b_q[`T16_CB_CS] == `T16_CS_STOP && !cnt_wr
        |=> $stable(count_value_reg_q))
        else $error("stopped counter moved");
    a_gate_idle: assert property (i_power_gate && !cnt_wr |=> $stable(count_value_reg_q))
        else $error("gated counter moved");
    a_capture_copy: assert property (cap_evt |=>
        snapshot_value_reg_q == $past(count_value_reg_q) && timer_flag_reg_q[`T16_F_CAP])
        else $error("capture missed");
    a_top_wrap: assert property (timer_tick && at_top && !cnt_wr
        |=> count_value_reg_q == `T16_BOTTOM)
        else $error("no wrap at ceiling");
    a_irq_gate: assert property (timer_flag_reg_q[`T16_F_CMPA]
        && timer_irq_enable_reg_q[`T16_F_CMPA] |=> o_irq[`T16_F_CMPA])
        else $error("enabled request not raised");
    a_pwm_a_off: assert property (mode == `T16_M_FP_A ##1 mode == `T16_M_FP_A
        |-> !o_match_wave_pins[0])
        else $error("channel A pwm while ceiling");
    a_ctrl_write: assert property (wr_at(`T16_A_CTRL_B) |=> ctrl_b_q == $past(i_bus_wdata))
        else $error("control write lost");

    c_capture: cover property (cap_evt);
    c_wrap_cmpa: cover property (timer_tick && at_top && mode == `T16_M_CTC_A);
    c_set_and_ack: cover property (match[0] && i_irq_ack[`T16_F_CMPA]);
    c_word_write: cover property (wr_at(`T16_A_CNT_H) ##1 cnt_wr);
endmodule

/* tb/t16_cpu_model.sv */
`timescale 1ns/100ps
module t16_cpu_model (
    input  wire logic         i_clock,
    output t16_pkg::t16_addr_t o_bus_addr,
    output logic              o_bus_wr,
    output logic              o_bus_rd,
    output t16_pkg::t16_byte_t o_bus_wdata,
    input  t16_pkg::t16_byte_t i_bus_rdata
);
    import t16_pkg::*;

    initial begin
        o_bus_addr  = 4'h0;
        o_bus_wr    = 1'b0;
        o_bus_rd    = 1'b0;
        o_bus_wdata = 8'h00;
    end

    // Called at a falling edge; an idle cycle follows each access so a strobe never re-rises
    task automatic wr8(input t16_addr_t a, input t16_byte_t d);
        o_bus_addr  = a;
        o_bus_wdata = d;
        o_bus_wr    = 1'b1;
        @(negedge i_clock);
        o_bus_wr    = 1'b0;
        // Released data lines must not look like a held value
        o_bus_wdata = ~d;
        @(negedge i_clock);
    endtask

    task automatic rd8(input t16_addr_t a, output t16_byte_t d);
        o_bus_addr = a;
        o_bus_rd   = 1'b1;
        @(negedge i_clock);
        o_bus_rd   = 1'b0;
        d          = i_bus_rdata;
        @(negedge i_clock);
    endtask

    task automatic wr16(input t16_addr_t a, input t16_word_t w);
        wr8(a + 4'h1, w[15:8]);
        wr8(a, w[7:0]);
    endtask

    task automatic rd16(input t16_addr_t a, output t16_word_t w);
        t16_byte_t lo;
        t16_byte_t hi;
        rd8(a, lo);
        rd8(a + 4'h1, hi);
        w = {hi, lo};
    endtask
endmodule

/* tb/tb_timer16_core_and_byte_access.sv */
`timescale 1ns/100ps
`include "t16_cfg.svh"
module tb_timer16_core_and_byte_access;
    import t16_pkg::*;
    logic       i_clock;
    logic       i_rst_b;
    logic       i_power_gate;
    t16_addr_t  bus_addr;
    logic       bus_wr;
    logic       bus_rd;
    t16_byte_t  bus_wdata;
    t16_byte_t  bus_rdata;
    t16_presc_t i_presc_tick;
    logic       i_ext;
    logic       i_snap;
    logic       i_cmp_event;
    logic [5:0] i_irq_ack;
    t16_chan_t  wave;
    logic [5:0] irq;
    int         n_mismatch;
    int         checks;
    int         cycles;

    t16_core u_t16_core (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_power_gate(i_power_gate),
        .i_bus_addr(bus_addr), .i_bus_wr(bus_wr), .i_bus_rd(bus_rd),
        .i_bus_wdata(bus_wdata), .i_presc_tick(i_presc_tick),
        .i_external_tick_pin(i_ext), .i_snapshot_trigger_pin(i_snap),
        .i_cmp_event(i_cmp_event), .i_irq_ack(i_irq_ack),
        .o_bus_rdata(bus_rdata), .o_match_wave_pins(wave), .o_irq(irq)
    );

    t16_cpu_model u_t16_cpu_model (
        .i_clock(i_clock), .o_bus_addr(bus_addr), .o_bus_wr(bus_wr),
        .o_bus_rd(bus_rd), .o_bus_wdata(bus_wdata), .i_bus_rdata(bus_rdata)
    );

    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic check(input string s, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
        end
    endtask

    task automatic w8(input t16_addr_t a, input t16_byte_t d);
        u_t16_cpu_model.wr8(a, d);
    endtask
    task automatic w16(input t16_addr_t a, input t16_word_t d);
        u_t16_cpu_model.wr16(a, d);
    endtask
    task automatic cw(input t16_addr_t a, input t16_word_t e, input string s);
        t16_word_t v;
        u_t16_cpu_model.rd16(a, v);
        check(s, v, e);
    endtask
    task automatic cb(input t16_addr_t a, input t16_byte_t e, input string s);
        t16_byte_t v;
        u_t16_cpu_model.rd8(a, v);
        check(s, {8'h00, v}, {8'h00, e});
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            i_presc_tick = 4'h1;
            @(negedge i_clock);
            i_presc_tick = 4'h0;
            @(negedge i_clock);
        end
    endtask

    task automatic t_reset();
        // Address 0xF is unmapped and must read zero as well
        for (int a = 0; a < 16; a++) begin
            cb(a[3:0], 8'h00, "reset value");
        end
        check("irq after reset", {10'h000, irq}, 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_access();
        w16(`T16_A_CNT_L, 16'h01FF);
        cw(`T16_A_CNT_L, 16'h01FF, "counter word");
        repeat (20) @(negedge i_clock);
        cw(`T16_A_CNT_L, 16'h01FF, "stopped counter");
        w16(`T16_A_CMPA_L, 16'hA5C3);
        w8(`T16_A_CMPB_H, 8'h12);
        w8(`T16_A_CMPB_L, 8'h34);
        w8(`T16_A_CMPC_L, 8'h56);
        cw(`T16_A_CMPC_L, 16'h1256, "reused high byte");
        cw(`T16_A_CMPB_L, 16'h1234, "compare b");
        cb(`T16_A_CNT_L, 8'hFF, "counter low");
        cb(`T16_A_CMPA_H, 8'hA5, "compare high direct");
        cb(`T16_A_CNT_H, 8'h01, "latched high");
        cb(`T16_A_CNT_H, 8'h01, "temp holds");
        w8(`T16_A_CMPC_H, 8'h7E);
        cb(`T16_A_CNT_H, 8'h7E, "shared temp");
        w8(`T16_A_CTRL_C, 8'h80);
        cb(`T16_A_CTRL_C, 8'h80, "control byte");
        w8(`T16_A_CTRL_C, 8'h00);
        $display("test access done");
    endtask

    task automatic t_count();
        w16(`T16_A_CNT_L, 16'hFFFE);
        w16(`T16_A_CMPA_L, 16'h0001);
        w8(`T16_A_MASK, 8'h01);
        i_power_gate = 1'b1;
        w8(`T16_A_CTRL_B, 8'h02);
        tick(2);
        cw(`T16_A_CNT_L, 16'hFFFE, "gated counter");
        i_power_gate = 1'b0;
        tick(1);
        cw(`T16_A_CNT_L, 16'hFFFF, "counter at max");
        // A match needs a tick while the counter already sits on the compare value
        tick(3);
        cb(`T16_A_FLAG, 8'h03, "wrap and match flags");
        check("masked irq", {10'h000, irq}, 16'h0001);
        w8(`T16_A_MASK, 8'h2F);
        @(negedge i_clock);
        check("unmasked irq", {10'h000, irq}, 16'h0003);
        w8(`T16_A_FLAG, 8'h01);
        cb(`T16_A_FLAG, 8'h02, "write one clears");
        i_irq_ack = 6'h02;
        @(negedge i_clock);
        i_irq_ack = 6'h00;
        cb(`T16_A_FLAG, 8'h00, "ack clears");
        w8(`T16_A_CNT_H, 8'h12);
        // Tick lands on the same edge as the low-byte write
        fork
            w8(`T16_A_CNT_L, 8'h34);
            tick(1);
        join
        cw(`T16_A_CNT_L, 16'h1234, "write beats count");
        $display("test count done");
    endtask

    task automatic t_sources();
        t16_presc_t sel;
        t16_word_t  v;
        for (int cs = 1; cs < 8; cs++) begin
            w8(`T16_A_CTRL_B, 8'h00);
            w16(`T16_A_CNT_L, 16'h0000);
            w8(`T16_A_CTRL_B, 8'(cs));
            if (cs == 1) begin
                w8(`T16_A_CTRL_B, 8'h00);
                u_t16_cpu_model.rd16(`T16_A_CNT_L, v);
                check("free run", 16'(v != 16'h0000 && v < 16'h0004), 16'h0001);
            end else if (cs < 6) begin
                sel = 4'(1 << (cs - 2));
                i_presc_tick = ~sel;
                @(negedge i_clock);
                i_presc_tick = sel;
                @(negedge i_clock);
                i_presc_tick = 4'h0;
                cw(`T16_A_CNT_L, 16'h0001, "prescaled count");
            end else begin
                i_ext = 1'b1;
                repeat (6) @(negedge i_clock);
                cw(`T16_A_CNT_L, (cs == 7) ? 16'h0001 : 16'h0000, "pin rise");
                i_ext = 1'b0;
                repeat (6) @(negedge i_clock);
                cw(`T16_A_CNT_L, 16'h0001, "pin fall");
            end
        end
        $display("test sources done");
    endtask

    task automatic t_ceiling();
        t16_word_t tops [9] = '{16'h00FF, 16'h01FF, 16'h03FF, 16'h0010, 16'h0020, 16'h00FF,
                                16'h01FF, 16'h03FF, 16'h0020};
        t16_byte_t ca [9] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'h02};
        t16_byte_t cbv [9] = '{8'h02, 8'h02, 8'h02, 8'h0A, 8'h1A, 8'h0A, 8'h0A, 8'h0A, 8'h1A};
        w16(`T16_A_CMPA_L, 16'h0010);
        for (int i = 0; i < 9; i++) begin
            w8(`T16_A_CTRL_A, ca[i]);
            w8(`T16_A_CTRL_B, cbv[i] & 8'hF8);
            if (i == 4) begin
                w16(`T16_A_CAP_L, 16'h0020);
            end
            w16(`T16_A_CNT_L, tops[i] - 16'h0001);
            w8(`T16_A_CTRL_B, cbv[i]);
            tick(2);
            cw(`T16_A_CNT_L, 16'h0000, "wrap at ceiling");
        end
        // Mode 15: compare A is the ceiling, so channel A stays low while B follows its compare
        w8(`T16_A_CTRL_A, 8'h03);
        w16(`T16_A_CNT_L, 16'h0005);
        tick(1);
        @(negedge i_clock);
        check("channel a silent", {15'h0000, wave[0]}, 16'h0000);
        check("channel b output", {15'h0000, wave[1]}, 16'h0001);
        check("channel c output", {15'h0000, wave[2]}, 16'h0001);
        w8(`T16_A_CTRL_B, 8'h00);
        w8(`T16_A_CTRL_A, 8'h00);
        $display("test ceiling done");
    endtask

    task automatic t_capture();
        // Wraps and matches of the earlier tests are still pending
        w8(`T16_A_FLAG, 8'h2F);
        w8(`T16_A_CTRL_B, 8'h40);
        w16(`T16_A_CNT_L, 16'h4321);
        i_snap = 1'b1;
        repeat (8) @(negedge i_clock);
        cw(`T16_A_CAP_L, 16'h4321, "snapshot");
        cb(`T16_A_FLAG, 8'h20, "snapshot flag");
        i_irq_ack = 6'h20;
        @(negedge i_clock);
        i_irq_ack = 6'h00;
        cb(`T16_A_FLAG, 8'h00, "snapshot ack");
        w8(`T16_A_CTRL_B, 8'hC0);
        w16(`T16_A_CNT_L, 16'h1111);
        i_snap = 1'b0;
        repeat (12) @(negedge i_clock);
        // A two-cycle spike is shorter than the filter window
        i_snap = 1'b1;
        repeat (2) @(negedge i_clock);
        i_snap = 1'b0;
        repeat (12) @(negedge i_clock);
        cw(`T16_A_CAP_L, 16'h4321, "spike rejected");
        i_snap = 1'b1;
        repeat (12) @(negedge i_clock);
        cw(`T16_A_CAP_L, 16'h1111, "filtered edge");
        w8(`T16_A_CTRL_B, 8'h40);
        w8(`T16_A_CTRL_C, 8'h01);
        w16(`T16_A_CNT_L, 16'h2222);
        i_cmp_event = 1'b1;
        repeat (8) @(negedge i_clock);
        cw(`T16_A_CAP_L, 16'h2222, "comparator snapshot");
        w8(`T16_A_FLAG, 8'h20);
        cb(`T16_A_FLAG, 8'h00, "flag write one");
        $display("test capture done");
    endtask

    initial begin
        n_mismatch = 0;
        checks = 0;
        cycles = 0;
        i_rst_b = 1'b0;
        i_power_gate = 1'b0;
        i_presc_tick = 4'h0;
        i_ext = 1'b0;
        i_snap = 1'b0;
        i_cmp_event = 1'b0;
        i_irq_ack = 6'h00;
        repeat (3) @(negedge i_clock);
        i_rst_b = 1'b1;
        t_reset();
        t_access();
        t_count();
        t_sources();
        t_ceiling();
        t_capture();
        give_verdict();
    end
endmodule
